/* File: src/low_voltage_mode_controller.sv */
`timescale 1ns/1ps
module low_voltage_mode_controller (
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic nmi_a_i,
    input wire logic nmi_b_i,
    input wire logic irq_i,
    input wire logic clk_switched_i,
    input wire logic [2:0] option_settle_i,
    output logic main_osc_en_o,
    output logic subclock_sel_o,
    output logic [2:0] clock_divider_o,
    output logic [1:0] regulator_level_o,
    output logic cpu_run_o,
    output logic ext_serial_clk_en_o
);
    import lvm_pkg::*;

    settle_if sif ();

    settle_counter u_settle (
        .sys_clk_i(sys_clk_i),
        .srst_i(srst_i),
        .sif(sif)
    );

    // ==========================================================
    // input synchronisers
    logic [3:0] sync1_reg, sync2_reg;
    logic nmi_a_s, nmi_b_s, irq_s, switched_s;

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            sync1_reg <= 4'h0;
            sync2_reg <= 4'h0;
        end else begin
            sync1_reg <= {clk_switched_i, irq_i, nmi_b_i, nmi_a_i};
            sync2_reg <= sync1_reg;
        end
    end

    assign nmi_a_s = sync2_reg[0];
    assign nmi_b_s = sync2_reg[1];
    assign irq_s = sync2_reg[2];
    assign switched_s = sync2_reg[3];

    // ==========================================================
    // apb slave: answer one cycle into the access phase
    logic pready_reg, pready_next;
    logic pslverr_reg, pslverr_next;
    logic [31:0] prdata_reg, prdata_next;
    logic acc_phase, wr_en, addr_ok;
    logic [7:0] wbyte;

    assign acc_phase = psel_i && penable_i;
    assign wr_en = acc_phase && pready_reg && pwrite_i && addr_ok;
    assign wbyte = pwdata_i[7:0];

    // ==========================================================
    // register file state
    logic [7:0] vsel_reg, vsel_next;
    logic [7:0] key_reg, key_next;
    logic key_armed_reg, key_armed_next;
    logic [2:0] settle_sel_reg, settle_sel_next;
    logic [2:0] divider_reg, divider_next;
    logic sub_sel_reg, sub_sel_next;
    logic osc_stop_reg, osc_stop_next;
    logic [2:0] wake_mask_reg, wake_mask_next;
    logic stop_req;
    logic [2:0] option_reg;
    logic option_taken_reg;
    logic [2:0] strap1_reg, strap2_reg;
    pwr_state_t state_reg, state_next;

    // address decode and read mux
    always_comb begin
        addr_ok = 1'b1;
        prdata_next = 32'h0000_0000;
        case (paddr_i)
            ADDR_REG_VSEL: prdata_next[7:0] = vsel_reg;
            ADDR_REG_KEY: prdata_next[7:0] = key_reg;
            ADDR_SETTLE_SEL: prdata_next[2:0] = settle_sel_reg;
            ADDR_CLK_CTRL: begin
                prdata_next[CLK_DIV_LSB +: 3] = divider_reg;
                prdata_next[CLK_SUB_SEL_BIT] = sub_sel_reg;
                prdata_next[CLK_SRC_STAT_BIT] = switched_s;
                prdata_next[CLK_OSC_STOP_BIT] = osc_stop_reg;
            end
            ADDR_PWR_CTRL: prdata_next[2:0] = wake_mask_reg;
            ADDR_STATUS: begin
                prdata_next[3:0] = state_reg;
                prdata_next[5:4] = regulator_level_o;
            end
            default: addr_ok = 1'b0;
        endcase
        pready_next = acc_phase && !pready_reg;
        pslverr_next = acc_phase && !pready_reg && !addr_ok;
        if (!(acc_phase && !pready_reg)) begin
            prdata_next = 32'h0000_0000;
        end
    end

    // register writes and key protection
    always_comb begin
        vsel_next = vsel_reg;
        key_next = key_reg;
        key_armed_next = key_armed_reg;
        settle_sel_next = settle_sel_reg;
        divider_next = divider_reg;
        sub_sel_next = sub_sel_reg;
        osc_stop_next = osc_stop_reg;
        wake_mask_next = wake_mask_reg;
        stop_req = 1'b0;
        if (wr_en) begin
            key_armed_next = 1'b0; // any write to a mapped address disarms the key, except a KEY_ENABLE write to the key register, which arms it
            case (paddr_i)
                ADDR_REG_VSEL: begin
                    if (key_armed_reg) begin
                        vsel_next = wbyte;
                    end
                end
                ADDR_REG_KEY: begin
                    key_next = wbyte;
                    key_armed_next = (wbyte == KEY_ENABLE);
                end
                ADDR_SETTLE_SEL: settle_sel_next = pwdata_i[2:0];
                ADDR_CLK_CTRL: begin
                    divider_next = pwdata_i[CLK_DIV_LSB +: 3];
                    sub_sel_next = pwdata_i[CLK_SUB_SEL_BIT];
                    osc_stop_next = pwdata_i[CLK_OSC_STOP_BIT];
                end
                ADDR_PWR_CTRL: begin
                    wake_mask_next = pwdata_i[2:0];
                    stop_req = pwdata_i[PWR_STOP_BIT];
                end
                default: stop_req = 1'b0;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
            vsel_reg <= RST_VSEL;
            key_reg <= RST_KEY;
            key_armed_reg <= 1'b0;
            settle_sel_reg <= RST_SETTLE_SEL;
            divider_reg <= RST_DIVIDER;
            sub_sel_reg <= 1'b0;
            osc_stop_reg <= 1'b0;
            wake_mask_reg <= 3'h0;
        end else begin
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            prdata_reg <= prdata_next;
            vsel_reg <= vsel_next; // held across stop and wake
            key_reg <= key_next;
            key_armed_reg <= key_armed_next;
            settle_sel_reg <= settle_sel_next;
            divider_reg <= divider_next;
            sub_sel_reg <= sub_sel_next;
            osc_stop_reg <= osc_stop_next;
            wake_mask_reg <= wake_mask_next;
        end
    end

    // strap synchroniser, no reset so the strap is settled at release
    always_ff @(posedge sys_clk_i) begin
        strap1_reg <= option_settle_i;
        strap2_reg <= strap1_reg;
    end

    // option byte settle selector caught after reset release
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            option_reg <= 3'h0;
            option_taken_reg <= 1'b0;
        end else if (!option_taken_reg) begin
            option_reg <= strap2_reg;
            option_taken_reg <= 1'b1;
        end
    end

    // ==========================================================
    // power state machine
    logic wake;
    logic lv_stop_reg, lv_stop_next;

    // unmasked wake sources only
    assign wake = (nmi_a_s && !wake_mask_reg[PWR_NMI_A_MASK_BIT])
        || (nmi_b_s && !wake_mask_reg[PWR_NMI_B_MASK_BIT])
        || (irq_s && !wake_mask_reg[PWR_INT_MASK_BIT]);

    always_comb begin
        state_next = state_reg;
        lv_stop_next = lv_stop_reg;
        sif.start = 1'b0;
        sif.shift = 5'(SETTLE_BASE_SHIFT) + {2'b00, settle_sel_reg};
        case (state_reg)
            ST_RESET_WAIT: begin
                sif.shift = 5'(SETTLE_BASE_SHIFT) + {2'b00, option_reg};
                if (option_taken_reg && !sif.busy && !sif.done) begin
                    sif.start = 1'b1;
                end
                if (sif.done) begin
                    state_next = ST_RUN;
                end
            end
            ST_RUN: begin
                if (stop_req) begin
                    state_next = ST_STOP;
                    lv_stop_next = (vsel_reg == VSEL_LV_STOP);
                end
            end
            ST_STOP: begin
                if (wake) begin
                    sif.start = 1'b1;
                    lv_stop_next = 1'b0;
                    state_next = ST_SETTLE;
                end
            end
            ST_SETTLE: begin
                if (sif.done) begin
                    state_next = ST_RUN;
                end
            end
            default: state_next = ST_RESET_WAIT;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            state_reg <= ST_RESET_WAIT;
            lv_stop_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            lv_stop_reg <= lv_stop_next;
        end
    end

    // ==========================================================
    // clock and regulator outputs
    logic osc_en_next, lv_sub_next;
    logic [1:0] level_next;
    logic osc_en_reg, sub_sel_o_reg, run_reg, ser_en_reg;
    logic [2:0] div_o_reg;
    logic [1:0] level_reg;

    always_comb begin
        lv_sub_next = switched_s && (vsel_reg == VSEL_LV_SUB);
        osc_en_next = (state_next != ST_STOP)
            && !(osc_stop_reg && switched_s);
        if (lv_stop_next) begin
            level_next = REG_LVL_LV_STOP;
        end else if (lv_sub_next) begin
            level_next = REG_LVL_LV_SUB;
        end else begin
            level_next = REG_LVL_NORMAL;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            osc_en_reg <= 1'b1;
            sub_sel_o_reg <= 1'b0;
            div_o_reg <= RST_DIVIDER;
            level_reg <= REG_LVL_NORMAL;
            run_reg <= 1'b0;
            ser_en_reg <= 1'b1;
        end else begin
            osc_en_reg <= osc_en_next;
            sub_sel_o_reg <= sub_sel_next;
            div_o_reg <= divider_next;
            level_reg <= level_next;
            run_reg <= (state_next == ST_RUN);
            ser_en_reg <= !lv_sub_next;
        end
    end

    assign prdata_o = prdata_reg;
    assign pready_o = pready_reg;
    assign pslverr_o = pslverr_reg;
    assign main_osc_en_o = osc_en_reg;
    assign subclock_sel_o = sub_sel_o_reg;
    assign clock_divider_o = div_o_reg;
    assign regulator_level_o = level_reg;
    assign cpu_run_o = run_reg;
    assign ext_serial_clk_en_o = ser_en_reg;
endmodule

/* File: src/lvm_pkg.sv */
package lvm_pkg;
    // ==========================================================
    // register map (byte addresses, one word each)
    localparam logic [7:0] ADDR_REG_VSEL = 8'h00;
    localparam logic [7:0] ADDR_REG_KEY = 8'h04;
    localparam logic [7:0] ADDR_SETTLE_SEL = 8'h08;
    localparam logic [7:0] ADDR_CLK_CTRL = 8'h0C;
    localparam logic [7:0] ADDR_PWR_CTRL = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;
    // ==========================================================
    // values and keys
    localparam logic [7:0] VSEL_NORMAL = 8'h00;
    localparam logic [7:0] VSEL_LV_STOP = 8'h01;
    localparam logic [7:0] VSEL_LV_SUB = 8'h02;
    localparam logic [7:0] KEY_ENABLE = 8'hC9;
    localparam logic [7:0] KEY_LOCK = 8'h00;
    localparam logic [7:0] RST_VSEL = 8'h00;
    localparam logic [7:0] RST_KEY = 8'h00;
    localparam logic [2:0] RST_SETTLE_SEL = 3'h4;
    localparam logic [2:0] RST_DIVIDER = 3'h3;
    // ==========================================================
    // field positions
    localparam int CLK_DIV_LSB = 0;
    localparam int CLK_SUB_SEL_BIT = 3;
    localparam int CLK_SRC_STAT_BIT = 4;
    localparam int CLK_OSC_STOP_BIT = 6;
    localparam int PWR_NMI_A_MASK_BIT = 0;
    localparam int PWR_NMI_B_MASK_BIT = 1;
    localparam int PWR_INT_MASK_BIT = 2;
    localparam int PWR_STOP_BIT = 7;
    // ==========================================================
    // settle counter: count = 2 ** (base + selector)
    localparam int SETTLE_W = 20;
    localparam int SETTLE_BASE_SHIFT = 10;
    // regulator output levels
    localparam logic [1:0] REG_LVL_NORMAL = 2'h0;
    localparam logic [1:0] REG_LVL_LV_STOP = 2'h1;
    localparam logic [1:0] REG_LVL_LV_SUB = 2'h2;
    // power states
    typedef enum logic [3:0] {
        ST_RESET_WAIT = 4'b0001,
        ST_RUN = 4'b0010,
        ST_STOP = 4'b0100,
        ST_SETTLE = 4'b1000
    } pwr_state_t;
endpackage

/* File: src/settle_if.sv */
`timescale 1ns/1ps
interface settle_if;
    logic start;
    logic [4:0] shift;
    logic done;
    logic busy;
    modport ctrl (output start, output shift, input done, input busy);
    modport cnt (input start, input shift, output done, output busy);
endinterface

/* File: src/settle_counter.sv */
`timescale 1ns/1ps
module settle_counter (
    input wire logic sys_clk_i,
    input wire logic srst_i,
    settle_if.cnt sif
);
    import lvm_pkg::*;

    logic [SETTLE_W-1:0] count_reg, count_next;
    logic busy_reg, busy_next;
    logic done_reg, done_next;

    // ==========================================================
    // load on start, count down, pulse done once the count reaches zero
    always_comb begin
        count_next = count_reg;
        busy_next = busy_reg;
        done_next = 1'b0;
        if (sif.start) begin
            count_next = SETTLE_W'(({{(SETTLE_W-1){1'b0}}, 1'b1} << sif.shift) - 1'b1);
            busy_next = 1'b1;
        end else if (busy_reg) begin
            if (count_reg == '0) begin
                busy_next = 1'b0;
                done_next = 1'b1;
            end else begin
                count_next = count_reg - 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            count_reg <= '0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            busy_reg <= busy_next;
            done_reg <= done_next;
        end
    end

    assign sif.done = done_reg;
    assign sif.busy = busy_reg;
endmodule

/* File: verif/lvm_sva.sv */
`timescale 1ns/1ps
// ==========
// port checker for the power mode controller
module lvm_sva import lvm_pkg::*; (
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic pready_o,
    input wire logic nmi_a_i,
    input wire logic nmi_b_i,
    input wire logic irq_i,
    input wire logic [2:0] option_settle_i,
    input wire logic main_osc_en_o,
    input wire logic subclock_sel_o,
    input wire logic [2:0] clock_divider_o,
    input wire logic [1:0] regulator_level_o,
    input wire logic cpu_run_o,
    input wire logic ext_serial_clk_en_o
);
    logic wr_done;
    logic [2:0] mask_reg, mask_next, sel_reg, sel_next;
    logic rst_reg, rst_next;
    logic [17:0] cnt_reg, cnt_next;
    int need;
    // completed write and expected settle length
    assign wr_done = psel_i & penable_i & pready_o & pwrite_i;
    assign need = 1 << (SETTLE_BASE_SHIFT + int'(rst_reg ? option_settle_i : sel_reg));
    // track wake masks, settle selector and wait cycles
    always_comb begin
        mask_next = (wr_done && paddr_i == ADDR_PWR_CTRL) ? pwdata_i[2:0] : mask_reg;
        sel_next = (wr_done && paddr_i == ADDR_SETTLE_SEL) ? pwdata_i[2:0] : sel_reg;
        rst_next = srst_i | (rst_reg & ~cpu_run_o);
        cnt_next = (srst_i | cpu_run_o | ~main_osc_en_o) ? 18'h0 : cnt_reg + 18'h1;
        if (srst_i) begin
            mask_next = 3'h0;
            sel_next = RST_SETTLE_SEL;
        end
    end
    always_ff @(posedge sys_clk_i) begin
        mask_reg <= mask_next;
        sel_reg <= sel_next;
        rst_reg <= rst_next;
        cnt_reg <= cnt_next;
    end
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);
    sequence wr_to(logic [7:0] a);
        wr_done && paddr_i == a;
    endsequence
    sequence quiet_stop;
        (!cpu_run_o && !main_osc_en_o && !(irq_i && !mask_reg[2]) && !(nmi_a_i && !mask_reg[0])
            && !(nmi_b_i && !mask_reg[1])) [*3];
    endsequence
    AST_RESET_VALUES: assert property (disable iff (1'b0) srst_i |=> regulator_level_o == 2'h0
        && main_osc_en_o && !cpu_run_o && ext_serial_clk_en_o && clock_divider_o == RST_DIVIDER)
        else $error("reset values wrong");
    AST_STOP_ENTRY: assert property (wr_to(ADDR_PWR_CTRL) ##0 (pwdata_i[7] && cpu_run_o)
        |=> !main_osc_en_o && !cpu_run_o) else $error("stop entry wrong");
    AST_MASKED: assert property (quiet_stop |=> !main_osc_en_o) else $error("masked wake");
    AST_WAKE: assert property (regulator_level_o == 2'h1 && irq_i && !mask_reg[2]
        |-> ##[1:4] regulator_level_o == 2'h0 && main_osc_en_o) else $error("no wake");
    AST_RESET_WAIT: assert property ($rose(cpu_run_o) && rst_reg
        |-> cnt_reg >= need - 2 && cnt_reg <= need + 8) else $error("reset wait length");
    AST_WAKE_WAIT: assert property ($rose(cpu_run_o) && !rst_reg
        |-> cnt_reg >= need - 2 && cnt_reg <= need + 8) else $error("wake wait length");
    AST_CLK_SEL: assert property (wr_to(ADDR_CLK_CTRL) |=> subclock_sel_o == $past(pwdata_i[3])
        && clock_divider_o == $past(pwdata_i[2:0])) else $error("clock control wrong");
    AST_LV_SUB: assert property (regulator_level_o == 2'h2 |-> !ext_serial_clk_en_o
        && subclock_sel_o) else $error("low voltage subclock wrong");
endmodule
bind low_voltage_mode_controller lvm_sva i_sva (.sys_clk_i, .srst_i, .psel_i, .penable_i,
    .pwrite_i, .paddr_i, .pwdata_i, .pready_o, .nmi_a_i, .nmi_b_i, .irq_i, .option_settle_i,
    .main_osc_en_o, .subclock_sel_o, .clock_divider_o, .regulator_level_o, .cpu_run_o,
    .ext_serial_clk_en_o);

/* File: verif/low_voltage_mode_controller_bench.sv */
`timescale 1ns/1ps
// ==========
// bench for the power mode controller
module low_voltage_mode_controller_bench;
    import lvm_pkg::*;
    logic sys_clk_i, srst_i, psel_i, penable_i, pwrite_i, nmi_a_i, nmi_b_i, irq_i;
    logic clk_switched_i, pready_o, pslverr_o, main_osc_en_o, subclock_sel_o, cpu_run_o;
    logic ext_serial_clk_en_o, er;
    logic [7:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, rd;
    logic [2:0] option_settle_i, clock_divider_o;
    logic [1:0] regulator_level_o;
    logic [25:0] rows[13]; // write, address, data, expected read, expected error
    int failures = 0;
    int total_checks = 0;
    int cycles = 0;
    low_voltage_mode_controller i_dut (.sys_clk_i, .srst_i, .psel_i, .penable_i, .pwrite_i,
        .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .nmi_a_i, .nmi_b_i, .irq_i,
        .clk_switched_i, .option_settle_i, .main_osc_en_o, .subclock_sel_o, .clock_divider_o,
        .regulator_level_o, .cpu_run_o, .ext_serial_clk_en_o);
    // clock and hang limit
    initial begin
        sys_clk_i = 1'b0;
        forever #2.5 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            failures = failures + 1;
            finish_test();
        end
    end
    // ==========
    // tasks
    task automatic finish_test();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge sys_clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge sys_clk_i);
        end while (pready_o !== 1'b1);
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge sys_clk_i);
    endtask
    task automatic prot(input logic [7:0] v);
        apb(1'b1, ADDR_REG_KEY, {24'h0, KEY_ENABLE});
        apb(1'b1, ADDR_REG_VSEL, {24'h0, v}); // written between key enable and key lock
        apb(1'b1, ADDR_REG_KEY, {24'h0, KEY_LOCK});
    endtask
    task automatic run_within(input int lo, input int hi);
        int n;
        n = 0;
        while (cpu_run_o !== 1'b1 && n < hi) begin
            @(posedge sys_clk_i);
            n++;
        end
        check(32'(n >= lo && n < hi), 32'h1, "settle length");
    endtask
    // ==========
    // main sequence
    initial begin
        {srst_i, psel_i, penable_i, pwrite_i, nmi_a_i, nmi_b_i, irq_i, clk_switched_i} = 8'h80;
        paddr_i = 8'h00;
        pwdata_i = 32'h0;
        option_settle_i = 3'h0;
        rows = '{{1'b0, ADDR_REG_VSEL, 16'h0000, 1'b0}, {1'b0, ADDR_REG_KEY, 16'h0000, 1'b0},
            {1'b0, ADDR_SETTLE_SEL, 16'h0004, 1'b0}, {1'b0, ADDR_CLK_CTRL, 16'h0003, 1'b0},
            {1'b0, 8'h18, 16'h0000, 1'b1}, {1'b1, ADDR_REG_VSEL, 16'h0100, 1'b0},
            {1'b0, ADDR_REG_VSEL, 16'h0000, 1'b0}, {1'b1, ADDR_REG_KEY, 16'hC900, 1'b0},
            {1'b1, ADDR_REG_VSEL, 16'h0100, 1'b0}, {1'b1, ADDR_REG_KEY, 16'h0000, 1'b0},
            {1'b0, ADDR_REG_VSEL, 16'h0001, 1'b0}, {1'b0, ADDR_REG_KEY, 16'h0000, 1'b0},
            {1'b1, ADDR_SETTLE_SEL, 16'h0000, 1'b0}};
        repeat (2) @(posedge sys_clk_i);
        srst_i <= 1'b0;
        @(posedge sys_clk_i);
        check(32'({main_osc_en_o, cpu_run_o, ext_serial_clk_en_o, regulator_level_o}), 32'h14,
            "reset outputs");
        run_within(1015, 1040);
        foreach (rows[i]) begin
            apb(rows[i][25], rows[i][24:17], {24'h0, rows[i][16:9]});
            if (!rows[i][25]) begin
                check(rd, {24'h0, rows[i][8:1]}, "register read");
                check({31'h0, er}, {31'h0, rows[i][0]}, "slave error");
            end
        end
        // low-voltage stop, masked source, then interrupt wake
        apb(1'b1, ADDR_PWR_CTRL, 32'h82);
        @(posedge sys_clk_i);
        check(32'({cpu_run_o, main_osc_en_o, regulator_level_o}), 32'h1, "stop entry");
        nmi_b_i <= 1'b1;
        repeat (20) @(posedge sys_clk_i);
        check(32'({cpu_run_o, main_osc_en_o, regulator_level_o}), 32'h1, "masked wake");
        nmi_b_i <= 1'b0;
        irq_i <= 1'b1;
        repeat (5) @(posedge sys_clk_i);
        irq_i <= 1'b0;
        check(32'({cpu_run_o, main_osc_en_o, regulator_level_o}), 32'h4, "wake level");
        run_within(1005, 1030);
        apb(1'b0, ADDR_REG_VSEL, 32'h0);
        check(rd, 32'h1, "selector kept");
        apb(1'b0, ADDR_REG_KEY, 32'h0);
        check(rd, 32'h0, "key kept");
        prot(VSEL_NORMAL);
        apb(1'b0, ADDR_REG_VSEL, 32'h0);
        check(rd, 32'h0, "selector normal");
        // subclock, oscillator stop, low-voltage subclock
        apb(1'b1, ADDR_CLK_CTRL, 32'h0B); // divider kept at 3
        check(32'({subclock_sel_o, clock_divider_o}), 32'h0B, "subclock select");
        clk_switched_i <= 1'b1;
        repeat (4) @(posedge sys_clk_i);
        apb(1'b0, ADDR_CLK_CTRL, 32'h0);
        check(rd, 32'h1B, "switch status");
        apb(1'b1, ADDR_CLK_CTRL, 32'h4B); // main clock stopped first
        @(posedge sys_clk_i);
        check(32'({main_osc_en_o, cpu_run_o}), 32'h1, "osc stopped");
        check(32'({regulator_level_o, ext_serial_clk_en_o}), 32'h1, "serial clock on");
        prot(VSEL_LV_SUB);
        repeat (2) @(posedge sys_clk_i);
        check(32'({regulator_level_o, ext_serial_clk_en_o}), 32'h4, "lv subclock");
        // reset in mid-run with another strap value
        option_settle_i <= 3'h1;
        clk_switched_i <= 1'b0;
        srst_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        srst_i <= 1'b0;
        @(posedge sys_clk_i);
        check(32'({regulator_level_o, main_osc_en_o}), 32'h1, "reset mid run");
        apb(1'b0, ADDR_REG_VSEL, 32'h0);
        check(rd, 32'h0, "selector after reset");
        run_within(2030, 2070);
        finish_test();
    end
endmodule
